// >>> pkg/ppc_pkg.sv
package ppc_pkg;

    // ==========================================================
    // Register map (printed offsets are indices, byte address = 4x)
    // ==========================================================
    localparam logic [7:0] PPC_IDX_PRESCALE = 8'h03;
    localparam logic [7:0] PPC_IDX_ALIGN = 8'h04;
    localparam logic [7:0] PPC_IDX_CTRL = 8'h05;
    localparam logic [7:0] PPC_IDX_SWAP = 8'h06;
    localparam logic [7:0] PPC_IDX_SCALED = 8'h02;
    localparam logic [7:0] PPC_IDX_MODE = 8'h20;
    localparam int PPC_ADDR_SHIFT = 2;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int PPC_PCKA_LSB = 0;
    localparam int PPC_PCKB_LSB = 4;
    localparam int PPC_CODE_W = 3;
    localparam int PPC_PAIR_LSB = 4;
    localparam int PPC_WAIT_BIT = 3;
    localparam int PPC_FRZ_BIT = 2;
    localparam int PPC_PAIRS = 4;
    localparam int PPC_CH = 8;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] PPC_RST_BYTE = 8'h00;
    localparam logic [6:0] PPC_DIV_W = 7'd7;

    // Channels whose default base clock is A (others default to B)
    localparam logic [7:0] PPC_A_DEFAULT = 8'h33;

endpackage

// >>> verilog/ppc_divider.sv
`timescale 1ns/100ps
// ==========================================================
// Power-of-two prescaler: one free counter, tick per code
// ==========================================================
module ppc_divider
    import ppc_pkg::*;
#(
    parameter int CNT_W = 7
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic [2:0] code_a_i,
    input wire logic [2:0] code_b_i,
    // Ticks
    output logic tick_a_o,
    output logic tick_b_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic ta;
        logic tb;
    } ppc_div_state_t;

    ppc_div_state_t st;
    ppc_div_state_t next_st;

    // Tick when low 'code' bits all ones; code 0 ticks every cycle
    function automatic logic hit(input logic [CNT_W-1:0] c,
                                 input logic [2:0] code);
        logic [CNT_W-1:0] m;
        m = CNT_W'((1 << code) - 1);
        return ((c & m) == m);
    endfunction

    // Next state
    always_comb
    begin
        next_st = st;
        next_st.ta = 1'b0;
        next_st.tb = 1'b0;
        if (run_i)
        begin
            // Codes take effect at once; a glitched pulse is allowed
            next_st.cnt = st.cnt + CNT_W'(1);
            next_st.ta = hit(st.cnt, code_a_i);
            next_st.tb = hit(st.cnt, code_b_i);
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick_a_o = st.ta;
    assign tick_b_o = st.tb;

endmodule

// >>> verilog/ppc_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Three-flop synchroniser, change accepted when stages 2,3 agree
// ==========================================================
module ppc_sync
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Async level in, clean level out
    input wire logic d_i,
    output logic q_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } ppc_sync_state_t;

    ppc_sync_state_t st;
    ppc_sync_state_t next_st;

    // Stage 1 feeds only stage 2
    always_comb
    begin
        next_st = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3)
            next_st.q = st.s3;
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign q_o = st.q;

endmodule

// >>> verilog/ppc_ctrl.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module ppc_ctrl
    import ppc_pkg::*;
#(
    // Mask of channels present on this variant
    parameter logic [7:0] CH_PRESENT = 8'hFF
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Chip mode levels (from another domain)
    input wire logic wait_mode_i,
    input wire logic freeze_mode_i,
    // Scaled clocks from the rest of the unit
    input wire logic tick_sa_i,
    input wire logic tick_sb_i,
    // Base clock ticks
    output logic tick_a_o,
    output logic tick_b_o,
    // Per-channel control to the channel logic
    output logic [7:0] chan_tick_o,
    output logic [7:0] centre_align_bits_o,
    output logic [3:0] pair_o,
    output logic [7:0] out_enable_mask_o,
    output logic [7:0] high_byte_o,
    output logic prescaler_run_o
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [2:0] clock_a_divider_code; // Clock A rate
        logic [2:0] clock_b_divider_code; // Clock B rate
        logic [7:0] centre_align_bits; // Per-channel alignment
        logic [3:0] pair; // Pair ch6/7..ch0/1, msb first
        logic halt_prescaler_in_wait;
        logic halt_prescaler_in_freeze;
        logic [7:0] base_clock_swap_bits; // A/B swap per channel
        logic [7:0] scaled_sel; // Scaled clock per channel
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [7:0] ctick;
        logic [7:0] calign;
        logic [3:0] pair_q;
        logic [7:0] oen;
        logic [7:0] hib;
        logic run;
    } ppc_ctrl_state_t;

    ppc_ctrl_state_t st;
    ppc_ctrl_state_t next_st;

    logic wait_s; // Synchronised wait level
    logic frz_s; // Synchronised freeze level
    logic div_run; // Prescaler input gate
    logic tick_a;
    logic tick_b;
    logic [3:0] pair_ok; // Pairs whose channels both exist
    logic [7:0] idx; // Register index from byte address
    logic access; // Access phase of a transfer

    // ==========================================================
    // Mode synchronisers
    // ==========================================================
    ppc_sync u_sync_wait (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(wait_mode_i),
        .q_o(wait_s)
    );

    ppc_sync u_sync_frz (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(freeze_mode_i),
        .q_o(frz_s)
    );

    // Gate the prescaler input; registers are not gated at all
    assign div_run = !(st.halt_prescaler_in_wait && wait_s)
        && !(st.halt_prescaler_in_freeze && frz_s);

    // ==========================================================
    // Prescaler
    // ==========================================================
    ppc_divider #(
        .CNT_W(PPC_DIV_W)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(div_run),
        .code_a_i(st.clock_a_divider_code),
        .code_b_i(st.clock_b_divider_code),
        .tick_a_o(tick_a),
        .tick_b_o(tick_b)
    );

    // Pair bit only exists when both channels exist
    genvar g;
    generate
        for (g = 0; g < PPC_PAIRS; g++)
        begin : g_pair
            assign pair_ok[g] = CH_PRESENT[2*g] && CH_PRESENT[2*g+1];
        end
    endgenerate

    assign idx = paddr[PPC_ADDR_SHIFT+7:PPC_ADDR_SHIFT];
    assign access = psel && penable;

    // ==========================================================
    // Next state: registers, read mux, channel controls
    // ==========================================================
    always_comb
    begin
        logic [7:0] wb;
        logic sel_a;
        logic sc;
        logic [7:0] ctl;
        int k;
        wb = pwdata[7:0];
        sel_a = 1'b0;
        sc = 1'b0;
        ctl = PPC_RST_BYTE;
        k = 0;
        next_st = st;
        next_st.ready = 1'b0;
        next_st.err = 1'b0;
        // One wait state: answer in the cycle after setup+access
        if (access && !st.ready)
        begin
            next_st.ready = 1'b1;
            next_st.rdata = '0;
            ctl = {st.pair, st.halt_prescaler_in_wait,
                   st.halt_prescaler_in_freeze, 2'b00};
            // Any time, no lock
            case (idx)
                PPC_IDX_PRESCALE:
                begin
                    if (pwrite)
                    begin
                        next_st.clock_b_divider_code =
                            wb[PPC_PCKB_LSB +: PPC_CODE_W];
                        next_st.clock_a_divider_code =
                            wb[PPC_PCKA_LSB +: PPC_CODE_W];
                    end
                    next_st.rdata[7:0] = {1'b0, st.clock_b_divider_code,
                                          1'b0, st.clock_a_divider_code};
                end
                PPC_IDX_ALIGN:
                begin
                    if (pwrite)
                        next_st.centre_align_bits = wb & CH_PRESENT;
                    next_st.rdata[7:0] = st.centre_align_bits;
                end
                PPC_IDX_CTRL:
                begin
                    if (pwrite)
                    begin
                        next_st.pair = wb[PPC_PAIR_LSB +: PPC_PAIRS]
                            & pair_ok;
                        next_st.halt_prescaler_in_wait =
                            wb[PPC_WAIT_BIT];
                        next_st.halt_prescaler_in_freeze =
                            wb[PPC_FRZ_BIT];
                    end
                    next_st.rdata[7:0] = ctl;
                end
                PPC_IDX_SWAP:
                begin
                    if (pwrite)
                        next_st.base_clock_swap_bits = wb & CH_PRESENT;
                    next_st.rdata[7:0] = st.base_clock_swap_bits;
                end
                PPC_IDX_SCALED:
                begin
                    if (pwrite)
                        next_st.scaled_sel = wb & CH_PRESENT;
                    next_st.rdata[7:0] = st.scaled_sel;
                end
                PPC_IDX_MODE:
                begin
                    // Read-only view of live mode levels and gate
                    next_st.rdata[2:0] = {div_run, frz_s, wait_s};
                end
                default:
                begin
                    next_st.err = 1'b1;
                end
            endcase
        end
        // Per-channel controls; paired channels follow the odd one
        for (k = 0; k < PPC_CH; k++)
        begin
            // Odd channel's bits govern a pair, even's are ignored
            if ((k % 2 == 0) && st.pair[k/2])
            begin
                sel_a = PPC_A_DEFAULT[k+1] ^ st.base_clock_swap_bits[k+1];
                sc = st.scaled_sel[k+1];
                next_st.calign[k] = st.centre_align_bits[k+1];
                next_st.oen[k] = 1'b0;
                next_st.hib[k] = 1'b1;
            end
            else
            begin
                sel_a = PPC_A_DEFAULT[k] ^ st.base_clock_swap_bits[k];
                sc = st.scaled_sel[k];
                next_st.calign[k] = st.centre_align_bits[k];
                next_st.oen[k] = CH_PRESENT[k];
                next_st.hib[k] = 1'b0;
            end
            // Pick A, SA, B or SB
            next_st.ctick[k] = sel_a ? (sc ? tick_sa_i : tick_a)
                                     : (sc ? tick_sb_i : tick_b);
        end
        next_st.pair_q = st.pair;
        next_st.run = div_run;
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end

    // Outputs, all from flops (ticks are registered in the divider)
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.err;
    assign tick_a_o = tick_a;
    assign tick_b_o = tick_b;
    assign chan_tick_o = st.ctick;
    assign centre_align_bits_o = st.calign;
    assign pair_o = st.pair_q;
    assign out_enable_mask_o = st.oen;
    assign high_byte_o = st.hib;
    assign prescaler_run_o = st.run;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_code_hold;
        @(posedge clk_i) disable iff (rst_i)
        (access && !pready && pwrite && idx == PPC_IDX_PRESCALE)
        |=> (st.clock_a_divider_code == $past(pwdata[2:0]));
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("clock A code not written");

    property p_tick0;
        @(posedge clk_i) disable iff (rst_i)
        (st.clock_a_divider_code == 3'h0 && div_run) [*2] |=> tick_a;
    endproperty
    a_tick0: assert property (p_tick0)
        else $error("code zero must tick every cycle");

    property p_pair_absent;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |-> ((st.pair & ~pair_ok) == 4'h0);
    endproperty
    a_pair_absent: assert property (p_pair_absent)
        else $error("absent pair bit set");

    property p_align_absent;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |-> ((st.centre_align_bits & ~CH_PRESENT) == 8'h00);
    endproperty
    a_align_absent: assert property (p_align_absent)
        else $error("absent alignment bit set");

    property p_even_off;
        @(posedge clk_i) disable iff (rst_i)
        st.pair[0] |=> !out_enable_mask_o[0];
    endproperty
    a_even_off: assert property (p_even_off)
        else $error("paired even output enabled");

    property p_wait;
        @(posedge clk_i) disable iff (rst_i)
        (st.halt_prescaler_in_wait && wait_s) |=> !tick_a && !tick_b;
    endproperty
    a_wait: assert property (p_wait)
        else $error("prescaler ran in wait");

    property p_frz;
        @(posedge clk_i) disable iff (rst_i)
        (st.halt_prescaler_in_freeze && frz_s) |=> !tick_a;
    endproperty
    a_frz: assert property (p_frz)
        else $error("prescaler ran in freeze");

    property p_answer;
        @(posedge clk_i) disable iff (rst_i)
        $rose(access) |=> pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("no answer one cycle after access");

endmodule

// >>> dv/test_pwm_prescale_align_concat_ctrl.sv
`timescale 1ns/100ps
module test_pwm_prescale_align_concat_ctrl import ppc_pkg::*;;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, prdata_s, rd, rd_s;
    logic wait_mode_i, freeze_mode_i, tick_sa_i, tick_sb_i;
    logic tick_a_o, tick_b_o, prescaler_run_o, err;
    logic [7:0] chan_tick_o, centre_align_bits_o, out_enable_mask_o;
    logic [7:0] high_byte_o;
    logic [3:0] pair_o;
    int num_errors, comparisons, cycles, ca, cb;
    localparam logic [31:0] A_PRE = 32'(PPC_IDX_PRESCALE) << PPC_ADDR_SHIFT;
    localparam logic [31:0] A_ALN = 32'(PPC_IDX_ALIGN) << PPC_ADDR_SHIFT;
    localparam logic [31:0] A_CTL = 32'(PPC_IDX_CTRL) << PPC_ADDR_SHIFT;
    localparam logic [31:0] A_SWP = 32'(PPC_IDX_SWAP) << PPC_ADDR_SHIFT;
    localparam logic [31:0] A_SCL = 32'(PPC_IDX_SCALED) << PPC_ADDR_SHIFT;
    localparam logic [31:0] A_MOD = 32'(PPC_IDX_MODE) << PPC_ADDR_SHIFT;
    // Row: address, written word, expected read back
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } ppc_row_t;
    ppc_row_t rows [7] = '{'{A_PRE, 32'h0000_00FF, 32'h0000_0077},
        '{A_PRE, 32'h0000_0025, 32'h0000_0025},
        '{A_ALN, 32'h0000_00A5, 32'h0000_00A5},
        '{A_ALN, 32'hFFFF_FF5A, 32'h0000_005A},
        '{A_CTL, 32'h0000_00FC, 32'h0000_00FC},
        '{A_SWP, 32'h0000_003C, 32'h0000_003C},
        '{A_SCL, 32'h0000_00C3, 32'h0000_00C3}};
    // Mode rows: wait-stop, freeze-stop, expected gate, freeze, wait
    // The low three bits are also what the mode status view should read
    logic [4:0] modes [5] = '{5'b10001, 5'b00101, 5'b01010, 5'b10110,
        5'b01101};

    // Full variant
    ppc_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wait_mode_i(wait_mode_i), .freeze_mode_i(freeze_mode_i),
        .tick_sa_i(tick_sa_i), .tick_sb_i(tick_sb_i), .tick_a_o(tick_a_o),
        .tick_b_o(tick_b_o), .chan_tick_o(chan_tick_o),
        .centre_align_bits_o(centre_align_bits_o), .pair_o(pair_o),
        .out_enable_mask_o(out_enable_mask_o), .high_byte_o(high_byte_o),
        .prescaler_run_o(prescaler_run_o));
    // Four-channel variant on the same bus, only its read data is used
    ppc_ctrl #(.CH_PRESENT(8'h0F)) DUT_SMALL (.clk_i(clk_i), .rst_i(rst_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata_s), .pready(), .pslverr(),
        .wait_mode_i(wait_mode_i), .freeze_mode_i(freeze_mode_i),
        .tick_sa_i(tick_sa_i), .tick_sb_i(tick_sb_i), .tick_a_o(),
        .tick_b_o(), .chan_tick_o(), .centre_align_bits_o(), .pair_o(),
        .out_enable_mask_o(), .high_byte_o(), .prescaler_run_o());

    // ==========================================================
    // Clock and hang guard
    // ==========================================================
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Whole run needs about 2500 cycles; cut off well beyond that
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    // Compare seen against expected and count
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons = comparisons + 1;
        if (s !== e)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer; entered just after an edge, returns after one
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Wait for pready sampled at an edge; only the hang guard ends it
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        rd_s = prdata_s;
        err = pslverr;
        // The slave answers one cycle after it takes the access phase
        chk("access edges", 32'(n), 32'h2);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    // Count base ticks over a number of edges
    task automatic count(input int len);
        ca = 0;
        cb = 0;
        repeat (len)
        begin
            @(posedge clk_i);
            ca += int'(tick_a_o === 1'b1);
            cb += int'(tick_b_o === 1'b1);
        end
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        {psel, penable, pwrite, wait_mode_i, freeze_mode_i} = '0;
        {paddr, pwdata, num_errors, comparisons, cycles} = '0;
        tick_sa_i = 1'b1;
        tick_sb_i = 1'b0;
        rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, all zero
        apb(1'b0, A_ALN, '0);
        chk("align rst", rd, '0);
        apb(1'b0, A_CTL, '0);
        chk("ctrl rst", rd, '0);
        chk("pair rst", 32'(pair_o), '0);
        $display("reset test done");
        // Ordinary register rows
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, '0);
            chk("row read", rd, rows[i].e);
        end
        $display("register rows done");
        // Every prescale code on A, the mirror code on B
        for (int n = 0; n < 8; n++)
        begin
            apb(1'b1, A_PRE, 32'((7 - n) << 4 | n));
            count(256);
            chk("tick a", 32'(ca), 32'(256 >> n));
            chk("tick b", 32'(cb), 32'(256 >> (7 - n)));
        end
        $display("prescale test done");
        // Pair 0/1 and 4/5, leave 2/3 independent
        // Channels are taken as disabled while these bits change
        apb(1'b1, A_ALN, 32'h0A);
        apb(1'b1, A_CTL, 32'h50);
        apb(1'b1, A_SCL, 32'hFF);
        apb(1'b1, A_SWP, 32'h02);
        repeat (2) @(posedge clk_i);
        chk("pair", 32'(pair_o), 32'h5);
        chk("centre", 32'(centre_align_bits_o), 32'h0B);
        chk("high", 32'(high_byte_o), 32'h11);
        chk("outen", 32'(out_enable_mask_o), 32'hEE);
        chk("chtick", 32'(chan_tick_o), 32'h30);
        apb(1'b1, A_CTL, 32'h00);
        apb(1'b1, A_SWP, 32'hFF);
        repeat (2) @(posedge clk_i);
        chk("chtick swap", 32'(chan_tick_o), 32'hCC);
        chk("outen free", 32'(out_enable_mask_o), 32'hFF);
        // Swap the scaled sources so SA and SB are told apart
        tick_sa_i <= 1'b0;
        tick_sb_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("chtick sb", 32'(chan_tick_o), 32'h33);
        $display("pairing test done");
        // Wait and freeze gating, code 0 ticks every running cycle
        apb(1'b1, A_PRE, 32'h00);
        // Unscaled sources, so channel ticks follow the gate too
        apb(1'b1, A_SCL, 32'h00);
        foreach (modes[i])
        begin
            apb(1'b1, A_CTL, 32'(modes[i][4:3]) << 2);
            wait_mode_i <= modes[i][0];
            freeze_mode_i <= modes[i][1];
            // Mode levels pass a three-flop synchroniser first
            repeat (10) @(posedge clk_i);
            chk("run", 32'(prescaler_run_o), 32'(modes[i][2]));
            chk("chtick gate", 32'(chan_tick_o), 32'({8{modes[i][2]}}));
            count(16);
            chk("gated ticks", 32'(ca), 32'({modes[i][2], 4'h0}));
            apb(1'b0, A_MOD, '0);
            chk("mode view", rd, 32'(modes[i][2:0]));
            apb(1'b0, A_CTL, '0);
            chk("ctrl in mode", rd, 32'(modes[i][4:3]) << 2);
            wait_mode_i <= 1'b0;
            freeze_mode_i <= 1'b0;
            repeat (10) @(posedge clk_i);
            chk("resume", 32'(prescaler_run_o), 32'h1);
        end
        $display("low power test done");
        // Unmapped index refused, absent channels read zero
        apb(1'b0, 32'h3C, '0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rd, '0);
        apb(1'b1, A_ALN, 32'hFF);
        apb(1'b0, A_ALN, '0);
        chk("absent align", rd_s, 32'h0F);
        apb(1'b1, A_CTL, 32'hF0);
        apb(1'b0, A_CTL, '0);
        chk("absent pair", rd_s, 32'h30);
        // Reset in mid-run clears the registers
        do_reset();
        apb(1'b0, A_ALN, '0);
        chk("align rerst", rd, '0);
        $display("awkward cases done");
        test_done();
    end
endmodule
